/* design/axis_limit_home_abort.sv */
// per-axis limit, home, index and abort supervisor
//
// Contract
// RQ1: forward limit active blocks forward motion of that axis at once.
// RQ2: reverse limit active blocks reverse motion of that axis at once.
// RQ3: limit during motion requests ramped stop, servo kept on.
// RQ4: limit activation dispatches the limit handler if one is defined.
// RQ5: begin toward an active limit is refused with error code 022.
// RQ6: forward and reverse limit states readable as single bits.
// RQ7: every home input edge toggles the home logic state.
// RQ8: edge search slews until home state changes, then ramped stop.
// RQ9: commander should program a high deceleration before edge search.
// RQ10: index search slews in jog direction until index rises; home ignored.
// RQ11: full homing reverses, creeps at 256 counts/s, then seeks index forward.
// RQ12: after index in full homing, stop and zero the position.
// RQ13: home state readable as 0 for low and 1 for high.
// RQ14: abort transition stops motion commands with no ramp.
// RQ15: abort turns off motor of axes with shutoff-on-error set.
// RQ16: abort on axes without shutoff stops fast and keeps servo.
// RQ17: abort transition terminates every running motion program.
// RQ18: reset input low requests full controller reset.
// RQ19: general inputs readable individually; 8 or 16 by axis count.
// RQ20: all external inputs pass a two-stage synchroniser first.
// RQ21: limit, home and homing state kept separately per axis.
`timescale 1ns/100ps
`include "axis_limit_params.svh"
module axis_limit_home_abort
  import axis_limit_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // switch pins, asynchronous
  input wire logic [`NUM_AXES-1:0] forward_limit_in_i,
  input wire logic [`NUM_AXES-1:0] reverse_limit_in_i,
  input wire logic [`NUM_AXES-1:0] home_in_i,
  input wire logic [`NUM_AXES-1:0] index_in_i,
  input wire logic abort_in_i,
  input wire logic reset_in_n_i,
  input wire logic [`NUM_GP_IN-1:0] gp_in_i,
  // configuration from the controller core
  input wire logic limit_handler_defined_i,
  input wire logic [`NUM_AXES-1:0] shutoff_on_error_i,
  input wire logic [`NUM_AXES-1:0] jog_dir_rev_i,
  input wire logic [3:0] gp_index_i,
  // motion status and begin requests from the core
  input wire logic [`NUM_AXES-1:0] moving_i,
  input wire logic [`NUM_AXES-1:0] dir_rev_i,
  input wire logic [`NUM_AXES-1:0] begin_axis_cmd_i,
  input wire logic [`NUM_AXES-1:0] begin_dir_rev_i,
  input wire logic [1:0] begin_mode_i,
  input wire logic [`NUM_AXES-1:0] program_running_i,
  // motion inhibits and stop requests
  output logic [`NUM_AXES-1:0] fwd_inhibit_o,
  output logic [`NUM_AXES-1:0] rev_inhibit_o,
  output logic [`NUM_AXES-1:0] ramp_stop_o,
  output logic [`NUM_AXES-1:0] hard_stop_o,
  output logic [`NUM_AXES-1:0] motor_off_o,
  output logic [`NUM_AXES-1:0] program_kill_o,
  output logic controller_reset_o,
  // handler dispatch and begin errors
  output logic limit_dispatch_o,
  output logic begin_error_o,
  output logic [7:0] begin_error_code_o,
  // homing motion requests
  output logic [`NUM_AXES-1:0] home_slew_o,
  output logic [`NUM_AXES-1:0] home_dir_rev_o,
  output logic [`NUM_AXES-1:0] home_creep_o,
  output logic [`NUM_AXES-1:0] creep_step_o,
  output logic [`NUM_AXES-1:0] zero_position_o,
  output logic [`NUM_AXES-1:0] homing_done_o,
  // readable switch states
  output logic [`NUM_AXES-1:0] forward_limit_state_o,
  output logic [`NUM_AXES-1:0] reverse_limit_state_o,
  output logic [`NUM_AXES-1:0] home_state_axis_o,
  output logic abort_state_o,
  output logic [`NUM_GP_IN-1:0] gp_state_o,
  output logic gp_bit_o
);

  // ==========================================================
  // input synchronisation
  localparam int NSYNC = 4 * `NUM_AXES + 2 + `NUM_GP_IN;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync_in;
  logic [`NUM_AXES-1:0] fl_s;
  logic [`NUM_AXES-1:0] rl_s;
  logic [`NUM_AXES-1:0] home_s;
  logic [`NUM_AXES-1:0] idx_s;
  logic abort_s;
  logic reset_req_s;
  logic [`NUM_GP_IN-1:0] gp_s;

  // reset pin enters inverted: a cleared synchroniser means no reset
  assign raw_in = {gp_in_i, ~reset_in_n_i, abort_in_i, index_in_i,
                   home_in_i, reverse_limit_in_i, forward_limit_in_i};

  // every pin sees two flops before use
  input_sync #(.WIDTH(NSYNC)) u_sync ( // see RQ20
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .async_i(raw_in),
    .sync_o(sync_in)
  );

  assign {gp_s, reset_req_s, abort_s, idx_s, home_s, rl_s, fl_s} = sync_in;

  // ==========================================================
  // previous values for edge detection
  logic [`NUM_AXES-1:0] fl_q;
  logic [`NUM_AXES-1:0] rl_q;
  logic [`NUM_AXES-1:0] home_q;
  logic [`NUM_AXES-1:0] idx_q;
  logic abort_q;
  logic [`NUM_AXES-1:0] fl_rise;
  logic [`NUM_AXES-1:0] rl_rise;
  logic [`NUM_AXES-1:0] home_edge;
  logic [`NUM_AXES-1:0] idx_rise;
  logic abort_edge;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fl_q <= '0;
      rl_q <= '0;
      home_q <= '0;
      idx_q <= '0;
      abort_q <= 1'b0;
    end else begin
      fl_q <= fl_s;
      rl_q <= rl_s;
      home_q <= home_s;
      idx_q <= idx_s;
      abort_q <= abort_s;
    end
  end

  assign fl_rise = fl_s & ~fl_q;
  assign rl_rise = rl_s & ~rl_q;
  assign home_edge = home_s ^ home_q; // see RQ7
  assign idx_rise = idx_s & ~idx_q;
  assign abort_edge = abort_s ^ abort_q; // see RQ14

  // ==========================================================
  // creep step enable at 256 counts per second
  localparam logic [16:0] CREEP_LAST = 17'(`CREEP_DIV_CYCLES - 1);
  logic [16:0] creep_cnt;
  logic creep_tick;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      creep_cnt <= '0;
      creep_tick <= 1'b0;
    end else begin
      creep_tick <= (creep_cnt == CREEP_LAST);
      creep_cnt <= (creep_cnt == CREEP_LAST) ? 17'h0_0000 : creep_cnt + 1'b1;
    end
  end

  // ==========================================================
  // global outputs: reset, abort, general inputs, dispatch, errors
  logic [`NUM_AXES-1:0] begin_blocked;
  assign begin_blocked = begin_axis_cmd_i &
      ((fl_s & ~begin_dir_rev_i) | (rl_s & begin_dir_rev_i)); // see RQ5

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      controller_reset_o <= 1'b0;
      abort_state_o <= 1'b0;
      gp_state_o <= '0;
      gp_bit_o <= 1'b0;
      limit_dispatch_o <= 1'b0;
      begin_error_o <= 1'b0;
      begin_error_code_o <= 8'h00;
    end else begin
      controller_reset_o <= reset_req_s; // see RQ18
      abort_state_o <= abort_s;
      gp_state_o <= gp_s; // see RQ19
      gp_bit_o <= gp_s[gp_index_i]; // see RQ19
      // handler runs only when software has one
      limit_dispatch_o <= limit_handler_defined_i &
                          (|(fl_rise | rl_rise)); // see RQ4
      begin_error_o <= |begin_blocked; // see RQ5
      if (|begin_blocked) begin
        begin_error_code_o <= `LIMIT_ERR_CODE; // see RQ5
      end
    end
  end

  // ==========================================================
  // per-axis supervisor, independent state per axis
  genvar ax;
  generate
    for (ax = 0; ax < `NUM_AXES; ax++) begin : g_axis // see RQ21
      home_state_t hstate;
      home_state_t next_hstate;
      home_mode_t hmode;
      logic hdir;
      logic start_ok;

      assign start_ok = begin_axis_cmd_i[ax] & ~begin_blocked[ax] &
                        ~abort_edge;

      // homing sequencer next state
      always_comb begin
        next_hstate = hstate;
        case (hstate)
          HOME_IDLE: begin
            if (start_ok && home_mode_t'(begin_mode_i) != MODE_MOVE) begin
              next_hstate = HOME_RUN;
            end
          end
          HOME_RUN: begin
            if (hmode == MODE_INDEX && idx_rise[ax]) begin
              next_hstate = HOME_HALT; // see RQ10
            end else if (hmode == MODE_EDGE && home_edge[ax]) begin
              next_hstate = HOME_HALT; // see RQ8
            end else if (hmode == MODE_FULL && home_edge[ax]) begin
              next_hstate = HOME_STOP1;
            end
          end
          HOME_STOP1: begin
            if (!moving_i[ax]) begin
              next_hstate = HOME_CREEP; // see RQ11
            end
          end
          HOME_CREEP: begin
            if (home_edge[ax]) begin
              next_hstate = HOME_INDEX; // see RQ11
            end
          end
          HOME_INDEX: begin
            if (idx_rise[ax]) begin
              next_hstate = HOME_STOP2; // see RQ12
            end
          end
          HOME_STOP2: begin
            if (!moving_i[ax]) begin
              next_hstate = HOME_ZERO; // see RQ12
            end
          end
          HOME_ZERO: next_hstate = HOME_IDLE;
          HOME_HALT: begin
            if (!moving_i[ax]) begin
              next_hstate = HOME_IDLE;
            end
          end
          default: next_hstate = HOME_IDLE;
        endcase
        if (abort_edge) begin
          next_hstate = HOME_IDLE; // see RQ14
        end
      end

      // sequencer state, mode and direction
      always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          hstate <= HOME_IDLE;
          hmode <= MODE_MOVE;
          hdir <= 1'b0;
        end else begin
          hstate <= next_hstate;
          if (hstate == HOME_IDLE && start_ok) begin
            hmode <= home_mode_t'(begin_mode_i);
            // index search follows jog direction, others the switch
            hdir <= (home_mode_t'(begin_mode_i) == MODE_INDEX) ?
                    jog_dir_rev_i[ax] : home_s[ax]; // see RQ8
          end else if (hstate == HOME_STOP1 && !moving_i[ax]) begin
            hdir <= ~hdir; // see RQ11
          end else if (hstate == HOME_CREEP && home_edge[ax]) begin
            hdir <= 1'b0; // increasing count, see RQ11
          end
        end
      end

      // homing motion and zero-load outputs
      always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          home_slew_o[ax] <= 1'b0;
          home_dir_rev_o[ax] <= 1'b0;
          home_creep_o[ax] <= 1'b0;
          creep_step_o[ax] <= 1'b0;
          zero_position_o[ax] <= 1'b0;
          homing_done_o[ax] <= 1'b0;
        end else begin
          home_slew_o[ax] <= (next_hstate == HOME_RUN);
          home_dir_rev_o[ax] <= hdir;
          home_creep_o[ax] <= (hstate == HOME_CREEP) ||
                              (hstate == HOME_INDEX);
          creep_step_o[ax] <= creep_tick && ((hstate == HOME_CREEP) ||
                              (hstate == HOME_INDEX)); // see RQ11
          zero_position_o[ax] <= (hstate == HOME_ZERO); // see RQ12
          homing_done_o[ax] <= (hstate == HOME_ZERO) ||
              (hstate == HOME_HALT && !moving_i[ax]);
        end
      end

      // limits, stops, abort response and state reporting
      always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          fwd_inhibit_o[ax] <= 1'b0;
          rev_inhibit_o[ax] <= 1'b0;
          ramp_stop_o[ax] <= 1'b0;
          hard_stop_o[ax] <= 1'b0;
          motor_off_o[ax] <= 1'b0;
          program_kill_o[ax] <= 1'b0;
          forward_limit_state_o[ax] <= 1'b0;
          reverse_limit_state_o[ax] <= 1'b0;
          home_state_axis_o[ax] <= 1'b0;
        end else begin
          fwd_inhibit_o[ax] <= fl_s[ax]; // see RQ1
          rev_inhibit_o[ax] <= rl_s[ax]; // see RQ2
          // ramped stop on limit hit while moving toward it
          ramp_stop_o[ax] <= moving_i[ax] &&
              ((fl_s[ax] && !dir_rev_i[ax]) ||
               (rl_s[ax] && dir_rev_i[ax]) ||
               next_hstate == HOME_HALT ||
               next_hstate == HOME_STOP1 ||
               next_hstate == HOME_STOP2); // see RQ3
          hard_stop_o[ax] <= abort_edge && !shutoff_on_error_i[ax]; // see RQ16
          // motor off holds until a new begin is taken
          if (abort_edge && shutoff_on_error_i[ax]) begin
            motor_off_o[ax] <= 1'b1; // see RQ15
          end else if (start_ok) begin
            motor_off_o[ax] <= 1'b0;
          end
          program_kill_o[ax] <= abort_edge && program_running_i[ax]; // see RQ17
          forward_limit_state_o[ax] <= fl_s[ax]; // see RQ6
          reverse_limit_state_o[ax] <= rl_s[ax]; // see RQ6
          home_state_axis_o[ax] <= home_s[ax]; // see RQ13
        end
      end
    end
  endgenerate

endmodule : axis_limit_home_abort

/* design/axis_limit_params.svh */
// constants for the per-axis limit, home and abort supervisor
`ifndef AXIS_LIMIT_PARAMS_SVH
`define AXIS_LIMIT_PARAMS_SVH
`define NUM_AXES 4
`define NUM_GP_IN 16
`define LIMIT_ERR_CODE 8'h22
`define CLK_HZ 25000000
`define CREEP_SPEED_CPS 256
// creep step enable period: clock cycles per count at creep speed
`define CREEP_DIV_CYCLES (`CLK_HZ / `CREEP_SPEED_CPS)
`define SYNC_STAGES 2
`endif

/* design/axis_limit_pkg.sv */
// types shared by the supervisor design files
package axis_limit_pkg;
  // homing sequence states, one-hot
  typedef enum logic [7:0] {
    HOME_IDLE   = 8'h01,
    HOME_RUN    = 8'h02,
    HOME_STOP1  = 8'h04,
    HOME_CREEP  = 8'h08,
    HOME_INDEX  = 8'h10,
    HOME_STOP2  = 8'h20,
    HOME_ZERO   = 8'h40,
    HOME_HALT   = 8'h80
  } home_state_t;
  // homing mode requested with begin
  typedef enum logic [1:0] {
    MODE_MOVE  = 2'd0,
    MODE_EDGE  = 2'd1,
    MODE_INDEX = 2'd2,
    MODE_FULL  = 2'd3
  } home_mode_t;
endpackage : axis_limit_pkg

/* design/input_sync.sv */
// two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/100ps
module input_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // raw and synchronised inputs
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta;
  // first stage feeds only the second stage
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta <= '0;
      sync_o <= '0;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule : input_sync

/* verif/switch_field_model.sv */
// switch and encoder index model facing the supervisor pins
`timescale 1ns/100ps
module switch_field_model (
  // clock
  input wire logic clk_sys_i,
  // requested switch levels and shaft spin per axis
  input wire logic [3:0] fwd_set_i,
  input wire logic [3:0] rev_set_i,
  input wire logic [3:0] home_set_i,
  input wire logic [3:0] spin_i,
  input wire logic abort_set_i,
  // pins toward the supervisor
  output logic [3:0] fwd_pin_o = 4'h0,
  output logic [3:0] rev_pin_o = 4'h0,
  output logic [3:0] home_pin_o = 4'h0,
  output logic [3:0] index_pin_o = 4'h0,
  output logic abort_pin_o = 1'b0
);
  logic [3:0] angle = 4'h0;
  // contacts follow requests one clock later
  always @(posedge clk_sys_i) begin
    fwd_pin_o <= fwd_set_i;
    rev_pin_o <= rev_set_i;
    home_pin_o <= home_set_i;
    abort_pin_o <= abort_set_i;
  end
  // index high two cycles in sixteen while the shaft turns
  always @(posedge clk_sys_i) begin
    angle <= angle + 4'h1;
    index_pin_o <= spin_i & {4{angle[3:1] == 3'h7}};
  end
endmodule : switch_field_model

/* verif/axis_limit_home_abort_properties.sv */
// concurrent checks on the supervisor ports
`timescale 1ns/100ps
`include "axis_limit_params.svh"
module axis_limit_home_abort_properties (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // pins and controls
  input wire logic [`NUM_AXES-1:0] forward_limit_in_i,
  input wire logic [`NUM_AXES-1:0] home_in_i,
  input wire logic reset_in_n_i,
  input wire logic limit_handler_defined_i,
  input wire logic [`NUM_AXES-1:0] shutoff_on_error_i,
  input wire logic [`NUM_AXES-1:0] moving_i,
  input wire logic [`NUM_AXES-1:0] dir_rev_i,
  input wire logic [`NUM_AXES-1:0] begin_axis_cmd_i,
  input wire logic [`NUM_AXES-1:0] begin_dir_rev_i,
  input wire logic [1:0] begin_mode_i,
  input wire logic [`NUM_AXES-1:0] program_running_i,
  // outputs watched
  input wire logic [`NUM_AXES-1:0] fwd_inhibit_o,
  input wire logic [`NUM_AXES-1:0] ramp_stop_o,
  input wire logic [`NUM_AXES-1:0] hard_stop_o,
  input wire logic [`NUM_AXES-1:0] motor_off_o,
  input wire logic [`NUM_AXES-1:0] program_kill_o,
  input wire logic controller_reset_o,
  input wire logic limit_dispatch_o,
  input wire logic begin_error_o,
  input wire logic [7:0] begin_error_code_o,
  input wire logic [`NUM_AXES-1:0] home_state_axis_o,
  input wire logic abort_state_o,
  input wire logic [`NUM_AXES-1:0] forward_limit_state_o,
  input wire logic [`NUM_AXES-1:0] zero_position_o
);
  logic [2:0] warm_cnt;
  logic warm;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // cycles since reset release, saturating once history is valid
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      warm_cnt <= 3'h0;
    end else if (warm_cnt != 3'h5) begin
      warm_cnt <= warm_cnt + 3'h1;
    end
  end
  assign warm = (warm_cnt == 3'h5);
  // ==========================================================
  // assertions
  a_fwd_inhibit_follow: assert property (
    warm |-> fwd_inhibit_o == $past(forward_limit_in_i, 3))
    else $error("forward inhibit does not follow pin");
  a_home_state_follow: assert property (
    warm |-> home_state_axis_o == $past(home_in_i, 3))
    else $error("home state does not follow pin");
  a_reset_pin_report: assert property (
    warm |-> controller_reset_o == !$past(reset_in_n_i, 3))
    else $error("reset request does not follow pin");
  a_begin_refused: assert property (
    warm && begin_axis_cmd_i[0] && begin_mode_i == 2'd0
    && !begin_dir_rev_i[0] && fwd_inhibit_o[0]
    && $past(forward_limit_in_i[0], 2)
    |-> ##[1:2] begin_error_o && begin_error_code_o == 8'h22)
    else $error("begin toward limit not refused");
  a_ramp_on_limit: assert property (
    warm && moving_i[0] && !dir_rev_i[0] && fwd_inhibit_o[0]
    |-> ##[0:2] ramp_stop_o[0])
    else $error("no ramped stop at limit");
  a_dispatch_on_limit: assert property (
    warm && $rose(forward_limit_state_o[0]) && limit_handler_defined_i
    |-> ##[0:1] limit_dispatch_o)
    else $error("limit handler not dispatched");
  a_hard_stop_abort: assert property (
    warm && $changed(abort_state_o)
    |-> ##[0:1] hard_stop_o == ~shutoff_on_error_i)
    else $error("hard stop mask wrong on abort");
  a_motor_off_abort: assert property (
    warm && $changed(abort_state_o)
    |-> ##[0:2] (motor_off_o & shutoff_on_error_i) == shutoff_on_error_i)
    else $error("motor not turned off on abort");
  a_program_kill_abort: assert property (
    warm && $changed(abort_state_o)
    |-> ##[0:1] program_kill_o == program_running_i)
    else $error("programs not terminated on abort");
  // main scenarios reached
  c_refusal: cover property (begin_error_o);
  c_dispatch: cover property (limit_dispatch_o);
  c_zeroed: cover property (zero_position_o != 4'h0);
endmodule : axis_limit_home_abort_properties

bind axis_limit_home_abort axis_limit_home_abort_properties chk (
  .clk_sys_i, .sys_rst_i, .forward_limit_in_i, .home_in_i, .reset_in_n_i,
  .limit_handler_defined_i, .shutoff_on_error_i, .moving_i, .dir_rev_i,
  .begin_axis_cmd_i, .begin_dir_rev_i, .begin_mode_i, .program_running_i,
  .fwd_inhibit_o, .ramp_stop_o, .hard_stop_o, .motor_off_o,
  .program_kill_o, .controller_reset_o, .limit_dispatch_o, .begin_error_o,
  .begin_error_code_o, .home_state_axis_o, .abort_state_o,
  .forward_limit_state_o, .zero_position_o);

/* verif/tb_axis_limit_home_abort.sv */
// self-checking bench for the limit, home and abort supervisor
`timescale 1ns/100ps
`include "axis_limit_params.svh"
module tb_axis_limit_home_abort
  import axis_limit_pkg::*;
;
  typedef struct packed {
    logic [3:0] f, r, h;
    logic [15:0] g;
    logic [3:0] i;
    logic b;
  } row_t;
  logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, reset_in_n_i = 1'b1;
  logic [3:0] fwd_set = 4'h0, rev_set = 4'h0, home_set = 4'h0, spin = 4'h0;
  logic abort_set = 1'b0, limit_handler_defined_i = 1'b0;
  logic [3:0] forward_limit_in_i, reverse_limit_in_i, home_in_i, index_in_i;
  logic abort_in_i;
  logic [15:0] gp_in_i = 16'h0000;
  logic [3:0] shutoff_on_error_i = 4'h0, jog_dir_rev_i = 4'h0;
  logic [3:0] gp_index_i = 4'h0, moving_i = 4'h0, dir_rev_i = 4'h0;
  logic [3:0] begin_axis_cmd_i = 4'h0, begin_dir_rev_i = 4'h0;
  logic [3:0] program_running_i = 4'h0;
  logic [1:0] begin_mode_i = 2'd0;
  logic [3:0] fwd_inhibit_o, rev_inhibit_o, ramp_stop_o, hard_stop_o;
  logic [3:0] motor_off_o, program_kill_o, home_slew_o, home_dir_rev_o;
  logic [3:0] home_creep_o, creep_step_o, zero_position_o, homing_done_o;
  logic [3:0] forward_limit_state_o, reverse_limit_state_o, home_state_axis_o;
  logic controller_reset_o, limit_dispatch_o, begin_error_o;
  logic abort_state_o, gp_bit_o;
  logic [7:0] begin_error_code_o;
  logic [15:0] gp_state_o;
  logic [3:0] hard_acc = 4'h0, kill_acc = 4'h0, done_acc = 4'h0;
  logic [3:0] zero_acc = 4'h0, creep_acc = 4'h0;
  int errors = 0, n_checks = 0, cycles = 0, disp_n = 0, err_n = 0;
  row_t rows [4] = '{'{4'h1, 4'h2, 4'h4, 16'h0001, 4'h0, 1'b1},
    '{4'h8, 4'h4, 4'hA, 16'h8000, 4'hF, 1'b1},
    '{4'h6, 4'h9, 4'h5, 16'h5A5A, 4'h2, 1'b0},
    '{4'h0, 4'h0, 4'h0, 16'h00FF, 4'h7, 1'b1}};

  axis_limit_home_abort dut (.clk_sys_i, .sys_rst_i, .forward_limit_in_i,
    .reverse_limit_in_i, .home_in_i, .index_in_i, .abort_in_i, .reset_in_n_i,
    .gp_in_i, .limit_handler_defined_i, .shutoff_on_error_i, .jog_dir_rev_i,
    .gp_index_i, .moving_i, .dir_rev_i, .begin_axis_cmd_i, .begin_dir_rev_i,
    .begin_mode_i, .program_running_i, .fwd_inhibit_o, .rev_inhibit_o,
    .ramp_stop_o, .hard_stop_o, .motor_off_o, .program_kill_o,
    .controller_reset_o, .limit_dispatch_o, .begin_error_o,
    .begin_error_code_o, .home_slew_o, .home_dir_rev_o, .home_creep_o,
    .creep_step_o, .zero_position_o, .homing_done_o, .forward_limit_state_o,
    .reverse_limit_state_o, .home_state_axis_o, .abort_state_o, .gp_state_o,
    .gp_bit_o);
  switch_field_model field (.clk_sys_i, .fwd_set_i(fwd_set),
    .rev_set_i(rev_set), .home_set_i(home_set), .spin_i(spin),
    .abort_set_i(abort_set), .fwd_pin_o(forward_limit_in_i),
    .rev_pin_o(reverse_limit_in_i), .home_pin_o(home_in_i),
    .index_pin_o(index_in_i), .abort_pin_o(abort_in_i));

  // clock and hang guard
  always #20 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      stop_test();
    end
  end
  // gather one-cycle pulses
  always @(posedge clk_sys_i) begin
    if (!sys_rst_i) begin
      disp_n <= disp_n + limit_dispatch_o;
      err_n <= err_n + begin_error_o;
      hard_acc <= hard_acc | hard_stop_o;
      kill_acc <= kill_acc | program_kill_o;
      done_acc <= done_acc | homing_done_o;
      zero_acc <= zero_acc | zero_position_o;
      creep_acc <= creep_acc | creep_step_o;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : wait_cyc
  task automatic begin_axis(input int a, input logic [1:0] m,
                            input logic r);
    @(posedge clk_sys_i);
    begin_axis_cmd_i[a] <= 1'b1;
    begin_mode_i <= m;
    begin_dir_rev_i[a] <= r;
    @(posedge clk_sys_i);
    begin_axis_cmd_i <= 4'h0;
    wait_cyc(2);
  endtask : begin_axis
  task automatic stop_test();
    if (errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  // ==========================================================
  // main sequence
  initial begin
    repeat (8) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    wait_cyc(1);
    check({controller_reset_o, hard_stop_o, motor_off_o, homing_done_o},
          16'h0000);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys_i);
      fwd_set <= rows[k].f;
      rev_set <= rows[k].r;
      home_set <= rows[k].h;
      gp_in_i <= rows[k].g;
      gp_index_i <= rows[k].i;
      wait_cyc(6);
      check(fwd_inhibit_o, rows[k].f);
      check(rev_inhibit_o, rows[k].r);
      check({forward_limit_state_o, reverse_limit_state_o},
            {rows[k].f, rows[k].r});
      check(home_state_axis_o, rows[k].h);
      check(gp_state_o, rows[k].g);
      check(gp_bit_o, rows[k].b);
    end
    gp_in_i <= 16'h1234;
    wait_cyc(2);
    check(gp_state_o, 16'h00FF);
    wait_cyc(1);
    check(gp_state_o, 16'h1234);
    check(16'(disp_n), 16'h0000);
    limit_handler_defined_i <= 1'b1;
    fwd_set <= 4'h1;
    wait_cyc(6);
    check(16'(disp_n), 16'h0001);
    begin_axis(0, MODE_MOVE, 1'b0);
    check(16'(err_n), 16'h0001);
    check(begin_error_code_o, 16'h0022);
    begin_axis(0, MODE_MOVE, 1'b1);
    check(16'(err_n), 16'h0001);
    moving_i <= 4'h1;
    wait_cyc(3);
    check(ramp_stop_o[0], 1'b1);
    moving_i <= 4'h0;
    fwd_set <= 4'h0;
    limit_handler_defined_i <= 1'b0;
    jog_dir_rev_i <= 4'h4;
    wait_cyc(6);
    // core halts at once after the edge, as a high deceleration would
    begin_axis(1, MODE_EDGE, 1'b0);
    check({home_slew_o[1], home_dir_rev_o[1]}, 16'h0002);
    home_set <= 4'h2;
    wait_cyc(6);
    check({home_slew_o[1], done_acc[1]}, 16'h0001);
    begin_axis(2, MODE_INDEX, 1'b0);
    check({home_slew_o[2], home_dir_rev_o[2]}, 16'h0003);
    home_set <= 4'h6;
    wait_cyc(6);
    check({home_slew_o[2], done_acc[2]}, 16'h0002);
    spin <= 4'h4;
    wait_cyc(30);
    check(done_acc[2], 1'b1);
    spin <= 4'h0;
    begin_axis(3, MODE_FULL, 1'b0);
    check({home_slew_o[3], home_dir_rev_o[3]}, 16'h0002);
    home_set <= 4'hE;
    wait_cyc(8);
    check({home_creep_o[3], home_dir_rev_o[3]}, 16'h0003);
    home_set <= 4'h6;
    wait_cyc(8);
    check({home_creep_o[3], home_dir_rev_o[3]}, 16'h0002);
    spin <= 4'h8;
    wait_cyc(40);
    check(zero_acc, 4'h8);
    check(done_acc, 4'hE);
    shutoff_on_error_i <= 4'h5;
    program_running_i <= 4'h3;
    abort_set <= 1'b1;
    wait_cyc(8);
    check(hard_acc, 4'hA);
    check(motor_off_o, 4'h5);
    check(kill_acc, 4'h3);
    reset_in_n_i <= 1'b0;
    abort_set <= 1'b0;
    wait_cyc(5);
    check({controller_reset_o, abort_state_o}, 16'h0002);
    reset_in_n_i <= 1'b1;
    sys_rst_i <= 1'b1;
    wait_cyc(2);
    sys_rst_i <= 1'b0;
    wait_cyc(1);
    check({controller_reset_o, motor_off_o}, 16'h0000);
    wait_cyc(1);
    check(controller_reset_o, 1'b0);
    // a creep step comes only after a full 256 counts/s period
    check(creep_acc, 4'h0);
    stop_test();
  end
endmodule : tb_axis_limit_home_abort
